// *** dhdlc_pkg.sv ***
// shared constants, types and helpers for the dual bit-oriented link controller
package dhdlc_pkg;
    localparam logic [1:0] PG_MST = 2'h0;
    localparam logic [1:0] PG_DL = 2'h1;
    localparam logic [1:0] PG_TS = 2'h2;
    localparam logic [4:0] A_ADR0 = 5'h10;
    localparam logic [4:0] A_ADR1 = 5'h11;
    localparam logic [4:0] A_CTL1 = 5'h13;
    localparam logic [4:0] A_STAT = 5'h14;
    localparam logic [4:0] A_SEL = 5'h14;
    localparam logic [4:0] A_CTL2 = 5'h15;
    localparam logic [4:0] A_THR = 5'h16;
    localparam logic [4:0] A_FIFO = 5'h17;
    localparam logic [4:0] A_RST = 5'h1B;
    localparam int C1_RXEN = 6;
    localparam int C1_TXEN = 5;
    localparam int C1_PEND = 4;
    localparam int C1_ABT = 3;
    localparam int C1_MARK = 2;
    localparam int C1_ADREC = 1;
    localparam int C2_NOCHK = 0;
    localparam int C2_TXLP = 1;
    localparam int C2_RXLP = 2;
    localparam int SEL_DL = 7;
    localparam int SEL_TS = 6;
    localparam int RST_SOFT = 0;
    localparam int FIFO_DEPTH = 128;
    localparam int FIFO_AW = 7;
    localparam logic [7:0] FIFO_FULL = 8'h80;
    localparam logic [7:0] THR_STEP = 8'h10;
    localparam logic [7:0] FLAG = 8'h7E;
    localparam logic [7:0] ABORT = 8'hFE;
    localparam logic [7:0] ONES = 8'hFF;
    localparam logic [8:0] GO_AHEAD = 9'h0FE;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [5:0] MIN_LEN = 6'h19;
    localparam logic [5:0] ABT_LEN = 6'h1A;
    localparam logic [5:0] GOOD_LEN = 6'h20;
    localparam logic [3:0] IDLE_ONES = 4'hF;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [1:0] TAG_BADEND = 2'h3;
    localparam logic [1:0] TAG_GOODEND = 2'h2;
    localparam logic [1:0] TAG_BYTE = 2'h0;
    typedef enum logic [1:0] {T_IDLE, T_FLAG, T_DATA, T_CHK} dhdlc_tst_t;
    // tx tag = {abort_tag, packet_end_tag}; rx tag = {rx_tag_upper, rx_tag_lower}
    typedef struct packed {logic [1:0] tag; logic [7:0] data;} dhdlc_ent_t;
    typedef struct packed {logic stb; logic val;} dhdlc_ln_t;
    // reflected form, shifting lsb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
    endfunction
    function automatic logic [7:0] thr_lvl(input logic [2:0] n);
        thr_lvl = {1'b0, n, 4'h0} + THR_STEP;
    endfunction
endpackage

// *** dhdlc_top.sv ***
// dual link controller: one per-channel engine and the host-facing top
`timescale 1ns/1ps
// Operation
// RL1: select bits 7 and 6 enable each controller; deselected controller interrupts masked (here select only gates irq; both engines always run)
// RL2: data-link controller runs at framer bit-slot rate of 4 to 20 kbit/s
// RL3: 128-byte fifos; thresholds 16 to 128 bytes in 16-byte steps
// RL4: frames bounded by 01111110; receiver hunts it bit by bit
// RL5: tx check x16+x12+x5+1 over data, complement sent msb first
// RL6: receive check must leave F0B8; good frames store data, drop check bytes
// RL7: zero inserted after five ones, check field included; receiver deletes it
// RL8: check mismatch writes last data byte tagged bad
// RL9: frames under 25 bits write nothing
// RL10: 25 to 31 bit frames store data, last byte tagged bad
// RL11: abort makes frame invalid; stored bytes stay after 26 bits
// RL12: tx abort is a zero then seven ones
// RL13: rx aborts on seven ones in a frame of 26 bits or more
// RL14: fifteen ones means idle; idle tx leaves wait when fifo gets data
// RL15: receiver detects go-ahead 011111110
// RL16: chip reset or soft reset clears control registers, disabling tx and rx
// RL17: separate tx and rx enables working independently
// RL18: loopbacks tx to rx and rx to tx
// RL19: rx bytes stored with two tag bits readable in status
// RL20: host write starts a packet; fifo entries carry end and abort tags
// RL21: empty fifo after packet sends flags or ones per idle selection
// RL22: single, dual and all-call address match; check inhibit; check result readable
// RL23: after the end-tagged byte send 16-bit check then closing flag
// RL24: tags 11 bad last, 01 bad, 10 good last, 00 ordinary
// RL25: fifo empties without end or abort tag: send abort
// RL26: idle-selection one sends flags, zero sends ones
// RL27: check generator and checker preset to all ones at each flag
// RL28: bytes sent and received lsb first

module dhdlc_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic sel,
    input wire logic tx_stb,
    input wire dhdlc_pkg::dhdlc_ln_t rx_in,
    output logic [7:0] rdata,
    output logic tx_bit_r,
    output logic irq_r
);
    logic srst_r, rst;
    logic [7:0] ctl1_r, ctl2_r, thr_r, adr0_r, adr1_r;
    dhdlc_pkg::dhdlc_ent_t tx_mem [dhdlc_pkg::FIFO_DEPTH];
    dhdlc_pkg::dhdlc_ent_t rx_mem [dhdlc_pkg::FIFO_DEPTH];
    dhdlc_pkg::dhdlc_ent_t bf_r [2];
    logic [7:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r, tx_cnt, rx_cnt;
    logic [1:0] bcnt_r;
    dhdlc_pkg::dhdlc_tst_t st_r, st_nxt;
    logic [15:0] sh_r, sh_nxt, crc_r;
    logic [4:0] bl_r, bl_nxt;
    logic stf_r, stf_nxt, dat_r, dat_nxt, inpkt_r, in_nxt, pend_r, pend_nxt, pop;
    logic [2:0] ones_r;
    logic [8:0] sr_r;
    logic [3:0] rones_r;
    logic [5:0] dly_r, nb_r;
    logic [2:0] fill_r, bc_r;
    logic [7:0] by_r;
    logic [7:0] h_r [3];
    logic [1:0] hv_r;
    logic [15:0] rcrc_r;
    logic infr_r, first_r, drop_r, ga_r, ovf_r;

    assign rst = !rst_n || srst_r; // [RL16]

    // host decode
    wire w_ctl1 = wr && addr == dhdlc_pkg::A_CTL1;
    wire tx_full = tx_cnt == dhdlc_pkg::FIFO_FULL;
    wire tx_emp = tx_cnt == 8'h00;
    wire rx_full = rx_cnt == dhdlc_pkg::FIFO_FULL;
    wire rx_emp = rx_cnt == 8'h00;
    wire tx_push = wr && addr == dhdlc_pkg::A_FIFO && !tx_full; // [RL20]
    wire rx_pop = rd && addr == dhdlc_pkg::A_FIFO && !rx_emp;
    wire rd_stat = rd && addr == dhdlc_pkg::A_STAT;
    assign tx_cnt = tx_wp_r - tx_rp_r;
    assign rx_cnt = rx_wp_r - rx_rp_r;
    wire txen = ctl1_r[dhdlc_pkg::C1_TXEN];
    wire rxen = ctl1_r[dhdlc_pkg::C1_RXEN];
    wire mark = ctl1_r[dhdlc_pkg::C1_MARK];
    wire adrec = ctl1_r[dhdlc_pkg::C1_ADREC];
    wire nochk = ctl2_r[dhdlc_pkg::C2_NOCHK];
    wire txlp = ctl2_r[dhdlc_pkg::C2_TXLP];
    wire rxlp = ctl2_r[dhdlc_pkg::C2_RXLP];
    wire rx_thr = rx_cnt >= dhdlc_pkg::thr_lvl(thr_r[2:0]); // [RL3]
    wire tx_low = tx_cnt < dhdlc_pkg::thr_lvl(thr_r[6:4]); // [RL3]
    dhdlc_pkg::dhdlc_ent_t head, rhead;
    assign head = tx_mem[tx_rp_r[dhdlc_pkg::FIFO_AW-1:0]];
    assign rhead = rx_mem[rx_rp_r[dhdlc_pkg::FIFO_AW-1:0]];
    wire r_idle = rones_r == dhdlc_pkg::IDLE_ONES; // [RL14]
    wire [7:0] stat = {rhead.tag, rx_emp, rx_thr, tx_full, ga_r, r_idle, ovf_r}; // [RL19] [RL24]

    always_comb begin
        unique case (addr)
            dhdlc_pkg::A_CTL1: rdata = ctl1_r;
            dhdlc_pkg::A_CTL2: rdata = ctl2_r;
            dhdlc_pkg::A_THR: rdata = thr_r;
            dhdlc_pkg::A_ADR0: rdata = adr0_r;
            dhdlc_pkg::A_ADR1: rdata = adr1_r;
            dhdlc_pkg::A_STAT: rdata = stat;
            dhdlc_pkg::A_FIFO: rdata = rhead.data;
            5'h18: rdata = rcrc_r[7:0]; // [RL22]
            5'h19: rdata = rcrc_r[15:8]; // [RL22]
            default: rdata = 8'h00;
        endcase
    end

    // self-clearing soft reset
    always_ff @(posedge clk) begin
        if (!rst_n) srst_r <= 1'b0;
        else srst_r <= wr && addr == dhdlc_pkg::A_RST && wdata[dhdlc_pkg::RST_SOFT]; // [RL16]
    end

    always_ff @(posedge clk) begin
        if (rst) begin // [RL16]
            ctl1_r <= 8'h00;
            ctl2_r <= 8'h00;
            thr_r <= 8'h00;
            adr0_r <= 8'h00;
            adr1_r <= 8'h00;
        end else begin
            if (w_ctl1) ctl1_r <= wdata; // [RL17]
            else if (tx_push) ctl1_r[dhdlc_pkg::C1_PEND:dhdlc_pkg::C1_ABT] <= 2'h0;
            if (wr && addr == dhdlc_pkg::A_CTL2) ctl2_r <= wdata;
            if (wr && addr == dhdlc_pkg::A_THR) thr_r <= wdata;
            if (wr && addr == dhdlc_pkg::A_ADR0) adr0_r <= wdata;
            if (wr && addr == dhdlc_pkg::A_ADR1) adr1_r <= wdata;
        end
    end

    // transmit fifo; tags latched from control one at write time
    always_ff @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_r[dhdlc_pkg::FIFO_AW-1:0]] <= {ctl1_r[dhdlc_pkg::C1_ABT], // [RL20]
                ctl1_r[dhdlc_pkg::C1_PEND], wdata};
        end
    end

    // transmit serializer
    wire stuffing = stf_r && ones_r == dhdlc_pkg::STUFF_RUN; // [RL7]
    wire ld = bl_r == 5'h00 && !stuffing;
    wire tx_out = stuffing ? 1'b0 : (bl_r != 5'h00 ? sh_r[0] : 1'b1); // [RL28]

    always_comb begin
        sh_nxt = {8'h00, dhdlc_pkg::FLAG}; // [RL4]
        bl_nxt = 5'h08;
        st_nxt = st_r;
        stf_nxt = 1'b0;
        dat_nxt = 1'b0;
        in_nxt = inpkt_r;
        pend_nxt = pend_r;
        pop = 1'b0;
        unique case (st_r)
            dhdlc_pkg::T_IDLE: begin
                if (txen && !tx_emp) begin // [RL14]
                    st_nxt = dhdlc_pkg::T_FLAG;
                    in_nxt = 1'b1;
                end else if (!(txen && mark)) begin
                    sh_nxt = {8'h00, dhdlc_pkg::ONES}; // [RL21] [RL26]
                end
            end
            dhdlc_pkg::T_CHK: begin
                st_nxt = dhdlc_pkg::T_FLAG; // [RL23]
                in_nxt = 1'b0;
            end
            dhdlc_pkg::T_FLAG, dhdlc_pkg::T_DATA: begin
                if (st_r == dhdlc_pkg::T_DATA && pend_r) begin
                    if (!nochk) begin
                        sh_nxt = ~crc_r; // [RL5] [RL23]
                        bl_nxt = 5'h10;
                        st_nxt = dhdlc_pkg::T_CHK;
                        stf_nxt = 1'b1; // [RL7]
                    end else begin
                        st_nxt = dhdlc_pkg::T_FLAG; // [RL22]
                        in_nxt = 1'b0;
                    end
                end else if (tx_emp) begin
                    st_nxt = dhdlc_pkg::T_IDLE;
                    in_nxt = 1'b0;
                    if (inpkt_r) sh_nxt = {8'h00, dhdlc_pkg::ABORT}; // [RL25]
                    // load the fill at once: an empty unit could meet a strobe and send a stray one
                    else if (!(txen && mark)) sh_nxt = {8'h00, dhdlc_pkg::ONES}; // [RL21]
                end else begin
                    pop = 1'b1;
                    if (head.tag[1]) begin
                        sh_nxt = {8'h00, dhdlc_pkg::ABORT}; // [RL12]
                        st_nxt = dhdlc_pkg::T_IDLE;
                        in_nxt = 1'b0;
                    end else begin
                        sh_nxt = {8'h00, head.data};
                        st_nxt = dhdlc_pkg::T_DATA;
                        stf_nxt = 1'b1;
                        dat_nxt = 1'b1;
                        in_nxt = 1'b1;
                        pend_nxt = head.tag[0];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_wp_r <= 8'h00;
            tx_rp_r <= 8'h00;
            st_r <= dhdlc_pkg::T_IDLE;
            sh_r <= 16'h0000;
            bl_r <= 5'h00;
            stf_r <= 1'b0;
            dat_r <= 1'b0;
            inpkt_r <= 1'b0;
            pend_r <= 1'b0;
            ones_r <= 3'h0;
            crc_r <= dhdlc_pkg::CRC_INIT;
            tx_bit_r <= 1'b1;
        end else begin
            if (tx_push) tx_wp_r <= tx_wp_r + 8'h01;
            if (ld) begin
                // a unit is loaded between strobes
                if (pop) tx_rp_r <= tx_rp_r + 8'h01;
                st_r <= st_nxt;
                sh_r <= sh_nxt;
                bl_r <= bl_nxt;
                stf_r <= stf_nxt;
                dat_r <= dat_nxt;
                inpkt_r <= in_nxt;
                pend_r <= pend_nxt;
                if (!stf_nxt) ones_r <= 3'h0;
                if (st_nxt == dhdlc_pkg::T_FLAG) crc_r <= dhdlc_pkg::CRC_INIT; // [RL27]
            end else if (tx_stb) begin
                if (stuffing) ones_r <= 3'h0; // [RL7]
                else begin
                    sh_r <= sh_r >> 1;
                    bl_r <= bl_r - 5'h01;
                    ones_r <= sh_r[0] ? ones_r + 3'h1 : 3'h0;
                    if (dat_r) crc_r <= dhdlc_pkg::crc_step(crc_r, sh_r[0]); // [RL5]
                end
            end
            if (tx_stb) tx_bit_r <= rxlp ? rx_in.val : tx_out; // [RL18]
        end
    end

    // receive side, optionally fed by the local transmitter
    dhdlc_pkg::dhdlc_ln_t rs;
    assign rs = txlp ? {tx_stb, tx_out} : rx_in; // [RL18]
    wire rb = rs.val;
    wire rstb = rs.stb && (rxen || infr_r); // [RL17]
    wire w_flag = {sr_r[6:0], rb} == dhdlc_pkg::FLAG; // [RL4]
    wire w_abt = rb && rones_r >= 4'h6; // [RL13]
    wire w_ga = {sr_r[7:0], rb} == dhdlc_pkg::GO_AHEAD; // [RL15]
    wire w_stuff = !rb && rones_r == 4'h5; // [RL7]
    wire w_push = infr_r && !w_stuff && !(rb && rones_r >= 4'h5);
    // six-bit lag keeps the closing flag's leading bits out of the data
    wire w_proc = w_push && fill_r == 3'h6 && !w_flag && !w_abt;
    wire w_dbit = dly_r[5];
    wire w_byte = rstb && w_proc && bc_r == 3'h7;
    wire w_end = rstb && w_flag && infr_r;
    wire w_abte = rstb && w_abt && infr_r && !w_flag;
    wire w_good = nb_r == dhdlc_pkg::GOOD_LEN && bc_r == 3'h0 && rcrc_r == dhdlc_pkg::CRC_GOOD; // [RL6]
    wire w_wreq = hv_r == 2'h3 && (w_byte || (w_end && nb_r >= dhdlc_pkg::MIN_LEN) // [RL9]
        || (w_abte && nb_r >= dhdlc_pkg::ABT_LEN)); // [RL11]
    wire [1:0] w_tag = w_byte ? dhdlc_pkg::TAG_BYTE :
        ((w_end && w_good) ? dhdlc_pkg::TAG_GOODEND : dhdlc_pkg::TAG_BADEND); // [RL8] [RL10] [RL24]
    // address bytes are still in the hold line when the first byte leaves
    wire a0_ok = !adr0_r[0] || h_r[2][7:1] == adr0_r[7:1] || &h_r[2][7:1];
    wire a1_ok = !adr1_r[0] || h_r[1][7:1] == adr1_r[7:1];
    wire w_aok = !adrec || !first_r || (a0_ok && a1_ok); // [RL22]
    wire w_wr = w_wreq && !drop_r && w_aok;
    wire b_in_rdy = bcnt_r != 2'h2;
    wire bpush = w_wr && b_in_rdy;
    wire bpop = bcnt_r != 2'h0 && !rx_full;
    wire ovf_ev = w_wr && !b_in_rdy;
    wire [1:0] widx = bcnt_r - {1'b0, bpop};

    always_ff @(posedge clk) begin
        if (bpop) begin
            rx_mem[rx_wp_r[dhdlc_pkg::FIFO_AW-1:0]] <= bf_r[0]; // [RL19]
            bf_r[0] <= bf_r[1];
        end
        if (bpush) bf_r[widx[0]] <= {w_tag, h_r[2]};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_wp_r <= 8'h00;
            rx_rp_r <= 8'h00;
            bcnt_r <= 2'h0;
            sr_r <= 9'h000;
            rones_r <= 4'h0;
            dly_r <= 6'h00;
            fill_r <= 3'h0;
            bc_r <= 3'h0;
            nb_r <= 6'h00;
            by_r <= 8'h00;
            h_r <= '{3{8'h00}};
            hv_r <= 2'h0;
            rcrc_r <= dhdlc_pkg::CRC_INIT;
            infr_r <= 1'b0;
            first_r <= 1'b0;
            drop_r <= 1'b0;
            ga_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            if (bpop) rx_wp_r <= rx_wp_r + 8'h01;
            if (rx_pop) rx_rp_r <= rx_rp_r + 8'h01;
            bcnt_r <= bcnt_r + {1'b0, bpush} - {1'b0, bpop};
            // status read clears sticky bits, a new event wins
            if (rd_stat) ga_r <= 1'b0;
            if (rd_stat) ovf_r <= 1'b0;
            if (ovf_ev) ovf_r <= 1'b1;
            if (rstb) begin
                sr_r <= {sr_r[7:0], rb};
                rones_r <= rb ? (r_idle ? rones_r : rones_r + 4'h1) : 4'h0;
                if (w_ga) ga_r <= 1'b1; // [RL15]
                if (w_flag) begin
                    infr_r <= rxen; // [RL4]
                    nb_r <= 6'h00;
                    bc_r <= 3'h0;
                    hv_r <= 2'h0;
                    fill_r <= 3'h0;
                    rcrc_r <= dhdlc_pkg::CRC_INIT; // [RL27]
                    first_r <= 1'b1;
                    drop_r <= 1'b0;
                end else if (w_abt) begin
                    infr_r <= 1'b0; // [RL11] [RL13]
                end else if (w_push) begin
                    dly_r <= {dly_r[4:0], rb};
                    if (fill_r != 3'h6) fill_r <= fill_r + 3'h1;
                    if (w_proc) begin
                        rcrc_r <= dhdlc_pkg::crc_step(rcrc_r, w_dbit); // [RL6]
                        by_r <= {w_dbit, by_r[7:1]}; // [RL28]
                        bc_r <= bc_r + 3'h1;
                        if (nb_r != dhdlc_pkg::GOOD_LEN) nb_r <= nb_r + 6'h01;
                        if (w_byte) begin
                            // index 0 newest, index 2 oldest
                            h_r <= '{{w_dbit, by_r[7:1]}, h_r[0], h_r[1]};
                            if (hv_r != 2'h3) hv_r <= hv_r + 2'h1;
                        end
                    end
                end
                if (w_wr) first_r <= 1'b0;
                // overflow drops the rest until the next opening flag
                if (!w_flag && ((w_wreq && !drop_r && !w_aok) || ovf_ev)) drop_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) irq_r <= 1'b0;
        else irq_r <= sel && (rx_thr || ovf_r || tx_low); // [RL1]
    end
endmodule // dhdlc_ctrl

module dhdlc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] host_page,
    input wire logic [4:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_r,
    input wire logic dl_tx_stb,
    output logic dl_tx_bit_r,
    input wire dhdlc_pkg::dhdlc_ln_t dl_rx,
    output logic dl_irq_r,
    input wire logic ts_tx_stb,
    output logic ts_tx_bit_r,
    input wire dhdlc_pkg::dhdlc_ln_t ts_rx,
    output logic ts_irq_r
);
    logic [7:0] sel_r, dl_rdata, ts_rdata;
    wire pg_dl = host_page == dhdlc_pkg::PG_DL;
    wire pg_ts = host_page == dhdlc_pkg::PG_TS;
    wire pg_m = host_page == dhdlc_pkg::PG_MST && host_addr == dhdlc_pkg::A_SEL;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_r <= 8'h00;
            host_rdata_r <= 8'h00;
        end else begin
            if (host_wr && pg_m) sel_r <= host_wdata; // [RL1]
            if (host_rd) host_rdata_r <= pg_dl ? dl_rdata : (pg_ts ? ts_rdata : (pg_m ? sel_r : 8'h00));
        end
    end

    // bit rate set by the framer's slot strobes
    dhdlc_ctrl u_dl (
        .clk(clk),
        .rst_n(rst_n),
        .wr(host_wr && pg_dl),
        .rd(host_rd && pg_dl),
        .addr(host_addr),
        .wdata(host_wdata),
        .sel(sel_r[dhdlc_pkg::SEL_DL]),
        .tx_stb(dl_tx_stb), // [RL2]
        .rx_in(dl_rx),
        .rdata(dl_rdata),
        .tx_bit_r(dl_tx_bit_r),
        .irq_r(dl_irq_r)
    );

    dhdlc_ctrl u_ts (
        .clk(clk),
        .rst_n(rst_n),
        .wr(host_wr && pg_ts),
        .rd(host_rd && pg_ts),
        .addr(host_addr),
        .wdata(host_wdata),
        .sel(sel_r[dhdlc_pkg::SEL_TS]),
        .tx_stb(ts_tx_stb),
        .rx_in(ts_rx),
        .rdata(ts_rdata),
        .tx_bit_r(ts_tx_bit_r),
        .irq_r(ts_irq_r)
    );
endmodule // dhdlc_top

// *** dhdlc_chk.sv ***
// port checker for the dual link controller top
`timescale 1ns/1ps
module dhdlc_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] host_page,
    input wire logic [4:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_r,
    input wire logic dl_tx_stb,
    input wire logic dl_tx_bit_r,
    input wire logic dl_irq_r,
    input wire logic ts_irq_r
);
    logic dl_sel_r;
    logic ts_sel_r;
    logic dl_en_r;
    wire sel_wr = host_wr && host_page == 2'h0 && host_addr == dhdlc_pkg::A_SEL;
    wire en_wr = host_wr && host_page == 2'h1 && host_addr == dhdlc_pkg::A_CTL1;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dl_sel_r <= 1'h0;
            ts_sel_r <= 1'h0;
            dl_en_r <= 1'h0;
        end else begin
            if (sel_wr) begin
                dl_sel_r <= host_wdata[dhdlc_pkg::SEL_DL];
                ts_sel_r <= host_wdata[dhdlc_pkg::SEL_TS];
            end
            // sticky: a disabled tx still finishes its packet
            if (en_wr && host_wdata[dhdlc_pkg::C1_TXEN]) begin
                dl_en_r <= 1'h1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_soft;
        host_wr && host_page == 2'h1 && host_addr == dhdlc_pkg::A_RST && host_wdata[dhdlc_pkg::RST_SOFT];
    endsequence
    sequence s_ctl_rd;
        !host_wr ##1 (host_rd && !host_wr && host_page == 2'h1 && host_addr == dhdlc_pkg::A_CTL1);
    endsequence
    // irq is registered, so one cycle of grace after deselect
    a_dl_mask: assert property (!dl_sel_r && !$past(dl_sel_r) |-> !dl_irq_r)
        else $error("dl irq while deselected");
    a_ts_mask: assert property (!ts_sel_r && !$past(ts_sel_r) |-> !ts_irq_r)
        else $error("ts irq while deselected");
    a_sel_read: assert property (host_rd && !host_wr && host_page == 2'h0 && host_addr == dhdlc_pkg::A_SEL
        |=> host_rdata_r[7:6] == {dl_sel_r, ts_sel_r})
        else $error("select readback wrong");
    a_bit_hold: assert property (!dl_tx_stb |=> $stable(dl_tx_bit_r))
        else $error("line bit moved without strobe");
    a_rd_hold: assert property (!host_rd |=> $stable(host_rdata_r))
        else $error("read data moved without read");
    a_rst_out: assert property (disable iff (1'h0) !rst_n |=> dl_tx_bit_r && !dl_irq_r && !ts_irq_r)
        else $error("outputs not at reset level");
    a_mark_idle: assert property (!dl_en_r |-> dl_tx_bit_r)
        else $error("line not idle ones before enable");
    a_soft_clear: assert property (s_soft ##1 s_ctl_rd |=> host_rdata_r == 8'h00)
        else $error("control not cleared by soft reset");
endmodule // dhdlc_chk
bind dhdlc_top dhdlc_chk u_dhdlc_chk (.clk(clk), .rst_n(rst_n), .host_page(host_page), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
    .dl_tx_stb(dl_tx_stb), .dl_tx_bit_r(dl_tx_bit_r), .dl_irq_r(dl_irq_r), .ts_irq_r(ts_irq_r));

// *** dhdlc_far.sv ***
// framer-side model: bit strobes and a line loop from tx back to rx
`timescale 1ns/1ps
module dhdlc_far (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic tx_bit,
    output logic tx_stb,
    output dhdlc_pkg::dhdlc_ln_t rx
);
    logic [2:0] cnt_r;
    logic stb_d_r;
    wire last = cnt_r == (slow ? 3'h6 : 3'h3);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            tx_stb <= 1'h0;
            stb_d_r <= 1'h0;
            rx <= 2'h0;
        end else begin
            cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
            tx_stb <= last;
            stb_d_r <= tx_stb;
            // idle line shows the inverted bit, never a stale copy
            rx <= stb_d_r ? {1'h1, tx_bit} : {1'h0, ~rx.val};
        end
    end
endmodule // dhdlc_far

// *** dhdlc_top_tb_top.sv ***
// bench for the dual link controller with a queue model of stored bytes
`timescale 1ns/1ps
module dhdlc_top_tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic slow = 1'h0;
    logic [1:0] host_page = 2'h0;
    logic [4:0] host_addr = 5'h00;
    logic host_wr = 1'h0;
    logic host_rd = 1'h0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata_r;
    logic [7:0] d;
    logic dl_tx_stb, dl_tx_bit_r, dl_irq_r, ts_tx_stb, ts_tx_bit_r, ts_irq_r;
    dhdlc_pkg::dhdlc_ln_t dl_rx, ts_rx;
    logic [9:0] exp_q[$];
    int errors = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    dhdlc_top u_dhdlc_top (.clk(clk), .rst_n(rst_n), .host_page(host_page), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
        .dl_tx_stb(dl_tx_stb), .dl_tx_bit_r(dl_tx_bit_r), .dl_rx(dl_rx), .dl_irq_r(dl_irq_r),
        .ts_tx_stb(ts_tx_stb), .ts_tx_bit_r(ts_tx_bit_r), .ts_rx(ts_rx), .ts_irq_r(ts_irq_r));
    dhdlc_far u_dl_far (.clk(clk), .rst_n(rst_n), .slow(slow), .tx_bit(dl_tx_bit_r), .tx_stb(dl_tx_stb), .rx(dl_rx));
    dhdlc_far u_ts_far (.clk(clk), .rst_n(rst_n), .slow(1'h0), .tx_bit(ts_tx_bit_r), .tx_stb(ts_tx_stb), .rx(ts_rx));
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one host access; read data lands in d
    task automatic acc(input logic w, input logic [1:0] p, input logic [4:0] a, input logic [7:0] v);
        host_page <= p;
        host_addr <= a;
        host_wdata <= v;
        host_wr <= w;
        host_rd <= !w;
        @(posedge clk);
        host_wr <= 1'h0;
        host_rd <= 1'h0;
        @(posedge clk);
        d = host_rdata_r;
    endtask
    // the receiver holds its newest two bytes as a possible check field
    task automatic send(input int n, input logic abt, input logic inh);
        logic [7:0] b[$];
        int l;
        for (int i = 0; i < n; i++) begin
            b.push_back(8'($urandom));
            if (i == n - 1) acc(1'h1, 2'h1, dhdlc_pkg::A_CTL1, abt ? 8'h6C : 8'h74);
            acc(1'h1, 2'h1, dhdlc_pkg::A_FIFO, b[i]);
        end
        l = (abt ? n - 1 : n) + ((abt || inh) ? 0 : 2);
        for (int i = 0; l >= 4 && i < l - 2; i++) begin
            exp_q.push_back({i < l - 3 ? 2'h0 : ((abt || inh) ? 2'h3 : 2'h2), b[i]});
        end
    endtask
    task automatic drain();
        logic [9:0] e;
        int k;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            k = 0;
            do begin
                acc(1'h0, 2'h1, dhdlc_pkg::A_STAT, 8'h00);
                k++;
            end while (d[5] !== 1'h0 && k < 600);
            if (d[5] !== 1'h0) begin
                errors++;
                finish_test();
            end
            chk("rx tag", {6'h00, e[9:8]}, {6'h00, d[7:6]});
            acc(1'h0, 2'h1, dhdlc_pkg::A_FIFO, 8'h00);
            chk("rx byte", e[7:0], d);
        end
        acc(1'h0, 2'h1, dhdlc_pkg::A_STAT, 8'h00);
        chk("rx empty", 8'h01, {7'h00, d[5]});
    endtask
    initial begin
        void'($urandom(25810));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        acc(1'h0, 2'h0, dhdlc_pkg::A_SEL, 8'h00);
        chk("select", 8'h00, d);
        acc(1'h0, 2'h3, 5'h00, 8'h00);
        chk("unmapped", 8'h00, d);
        acc(1'h1, 2'h1, dhdlc_pkg::A_CTL1, 8'h04);
        repeat (129) acc(1'h1, 2'h1, dhdlc_pkg::A_FIFO, 8'($urandom));
        acc(1'h0, 2'h1, dhdlc_pkg::A_STAT, 8'h00);
        chk("tx full", 8'h01, {7'h00, d[3]});
        acc(1'h1, 2'h1, dhdlc_pkg::A_RST, 8'h01);
        acc(1'h0, 2'h1, dhdlc_pkg::A_CTL1, 8'h00);
        chk("ctl1 soft", 8'h00, d);
        acc(1'h0, 2'h1, dhdlc_pkg::A_STAT, 8'h00);
        chk("fifo soft", 8'h02, {6'h00, d[5], d[3]});
        acc(1'h1, 2'h0, dhdlc_pkg::A_SEL, 8'h80);
        acc(1'h0, 2'h0, dhdlc_pkg::A_SEL, 8'h00);
        chk("select", 8'h80, d & 8'hC0);
        chk("dl irq", 8'h01, {7'h00, dl_irq_r});
        chk("ts irq", 8'h00, {7'h00, ts_irq_r});
        acc(1'h1, 2'h1, dhdlc_pkg::A_CTL1, 8'h64);
        send(1, 1'h0, 1'h0);
        send(2, 1'h0, 1'h0);
        send(2 + $urandom % 5, 1'h0, 1'h0);
        drain();
        slow <= 1'h1;
        send(6, 1'h1, 1'h0);
        send(3, 1'h0, 1'h0);
        drain();
        slow <= 1'h0;
        acc(1'h1, 2'h1, dhdlc_pkg::A_CTL2, 8'h01);
        send(4, 1'h0, 1'h1);
        drain();
        chk("ts line", 8'h01, {7'h00, ts_tx_bit_r});
        finish_test();
    end
endmodule // dhdlc_top_tb_top
